// *** verilog/ext_sample_clock_select.sv ***
// Sample clock source selector with AHB-Lite register access
// Overview of operation
// - Select register picks external or internal clock
// - Termination on only while connector is input
// - External path works down to DC
// - Range accepts five one-hot codes only
// - Divide external clock by permitted ratio
// - Reference zero internal, minus one backplane
// - No phase alignment between boards promised
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ns
module ext_sample_clock_select
    import clock_select_pkg::*;
(
    // Clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic [31:0]             hrdata,
    output logic                    hresp,
    // Board control and clock inputs
    input  wire logic               run,
    input  wire logic               ext_clk_in,
    input  wire logic               int_clk_tick,
    // Clock path outputs
    output logic                    sample_tick,
    output logic                    sample_clk,
    output logic                    term_enable,
    output logic                    connector_input,
    output logic [1:0]              pll_ref_select,
    output logic [RANGE_W-1:0]      ext_range_code
);

    // ========================================================================
    // Declarations
    // ========================================================================
    // Bus data phase
    logic              wr_pend_q;    // Write data phase pending
    logic              wr_pend_d;
    logic [15:0]       wr_idx_q;     // Register index of the write
    logic [15:0]       wr_idx_d;
    logic [31:0]       rdata_q;      // Read data register
    logic [31:0]       rdata_d;
    logic              addr_phase;   // Valid address phase this cycle
    logic [15:0]       ap_idx;       // Index decoded from haddr
    logic              ap_hit;       // Address is word aligned and in range

    // Software registers
    logic [31:0]       div_q,  div_d;     // Divider ratio
    logic [31:0]       ext_q,  ext_d;     // External select
    logic [31:0]       term_q, term_d;    // Termination request
    logic [31:0]       rng_q,  rng_d;     // Range code
    logic [31:0]       ref_q,  ref_d;     // Reference selection
    logic              rej_q,  rej_d;     // Last range or divider write refused

    // Active settings, copied while stopped
    logic              act_ext_q,  act_ext_d;
    logic [DIV_W-1:0]  act_div_q,  act_div_d;
    logic [RANGE_W-1:0] act_rng_q, act_rng_d;
    ref_src_t          act_ref_q,  act_ref_d;
    logic              act_term_q, act_term_d;
    ref_src_t          ref_decode;   // Reference decoded from register

    // Clock path
    logic              ext_prev_q;   // Previous external level
    logic              ext_edge;     // Rising edge of external clock
    logic              div_tick;     // Divided external tick
    logic              tick_q, tick_d;    // Registered sample tick
    logic              sclk_q, sclk_d;    // Sample clock level

    // ========================================================================
    // Address phase decode
    // ========================================================================
    // Byte address is four times the index; low bits must be zero
    always_comb
    begin
        addr_phase = hsel && htrans[1] && hready;
        ap_idx     = haddr[17:2];
        ap_hit     = (haddr[1:0] == 2'b00) && (haddr[31:ADDR_W] == '0);
    end

    // ========================================================================
    // Register file next values
    // ========================================================================
    always_comb
    begin
        div_d  = div_q;
        ext_d  = ext_q;
        term_d = term_q;
        rng_d  = rng_q;
        ref_d  = ref_q;
        rej_d  = rej_q;
        if (wr_pend_q)
        begin
            case (wr_idx_q)
                // Only permitted ratios are stored
                IDX_DIVIDER:
                begin
                    if (valid_ratio(hwdata))
                        div_d = hwdata;
                    rej_d = !valid_ratio(hwdata);
                end
                // Any non-zero value selects the external clock
                IDX_EXT_SELECT:  ext_d  = hwdata;
                IDX_TERMINATION: term_d = hwdata;
                // Only the five one-hot codes are stored
                IDX_RANGE:
                begin
                    if (valid_range(hwdata))
                        rng_d = hwdata;
                    rej_d = !valid_range(hwdata);
                end
                IDX_REFERENCE:   ref_d  = hwdata;
                // Status and unmapped words ignore writes
                default: ;
            endcase
        end
    end

    // ========================================================================
    // Bus phase next values and read mux
    // ========================================================================
    // Read data uses next register values so a write just before is seen
    always_comb
    begin
        wr_pend_d = addr_phase && hwrite && ap_hit;
        wr_idx_d  = addr_phase ? ap_idx : wr_idx_q;
        rdata_d   = rdata_q;
        if (addr_phase && !hwrite)
        begin
            rdata_d = 32'h0000_0000;
            if (ap_hit)
            begin
                case (ap_idx)
                    IDX_DIVIDER:     rdata_d = div_d;
                    IDX_EXT_SELECT:  rdata_d = ext_d;
                    IDX_TERMINATION: rdata_d = term_d;
                    IDX_RANGE:       rdata_d = rng_d;
                    IDX_REFERENCE:   rdata_d = ref_d;
                    // Live state of the block
                    IDX_STATUS:
                    begin
                        rdata_d[ST_RUN]               = run;
                        rdata_d[ST_EXT]               = act_ext_q;
                        rdata_d[ST_TERM]              = term_enable;
                        rdata_d[ST_REF_LSB +: 2]      = act_ref_q;
                        rdata_d[ST_CONN_IN]           = connector_input;
                        rdata_d[ST_REJECT]            = rej_d;
                    end
                    // Unmapped words read as zero
                    default: rdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    // Bus and register file flops
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 16'h0000;
            rdata_q   <= 32'h0000_0000;
            div_q     <= DIVIDER_RESET;
            ext_q     <= EXT_SELECT_RESET;
            term_q    <= TERMINATION_RESET;
            rng_q     <= RANGE_RESET;
            ref_q     <= REFERENCE_RESET;
            rej_q     <= 1'b0;
        end
        else
        begin
            wr_pend_q <= wr_pend_d;
            wr_idx_q  <= wr_idx_d;
            rdata_q   <= rdata_d;
            div_q     <= div_d;
            ext_q     <= ext_d;
            term_q    <= term_d;
            rng_q     <= rng_d;
            ref_q     <= ref_d;
            rej_q     <= rej_d;
        end
    end

    // ========================================================================
    // Active settings
    // ========================================================================
    // Zero is internal, minus one backplane, anything else the connector
    always_comb
    begin
        if (ref_q == REF_INTERNAL_CODE)
            ref_decode = REF_SRC_INTERNAL;
        else if (ref_q == backplane_reference_code)
            ref_decode = REF_SRC_BACKPLANE;
        else
            ref_decode = REF_SRC_CONNECTOR;
    end

    // Settings follow the registers only while the board is stopped
    always_comb
    begin
        act_ext_d  = act_ext_q;
        act_div_d  = act_div_q;
        act_rng_d  = act_rng_q;
        act_ref_d  = act_ref_q;
        act_term_d = act_term_q;
        if (!run)
        begin
            act_ext_d  = (ext_q != 32'h0000_0000);
            act_div_d  = div_q[DIV_W-1:0];
            act_rng_d  = rng_q[RANGE_LSB +: RANGE_W];
            act_ref_d  = ref_decode;
            act_term_d = (term_q != 32'h0000_0000);
        end
    end

    // Active settings flops
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            act_ext_q  <= 1'b0;
            act_div_q  <= DIVIDER_RESET[DIV_W-1:0];
            act_rng_q  <= RANGE_RESET[RANGE_LSB +: RANGE_W];
            act_ref_q  <= REF_SRC_INTERNAL;
            act_term_q <= 1'b0;
        end
        else
        begin
            act_ext_q  <= act_ext_d;
            act_div_q  <= act_div_d;
            act_rng_q  <= act_rng_d;
            act_ref_q  <= act_ref_d;
            act_term_q <= act_term_d;
        end
    end

    // ========================================================================
    // External clock divider
    // ========================================================================
    // Held cleared while the internal clock is chosen
    ratio_divider u_divider (
        .clk      (hclk),
        .rst_n    (hresetn),
        .clear    (!act_ext_q),
        .ratio    (act_div_q),
        .tick_in  (ext_edge),
        .tick_out (div_tick)
    );

    // ========================================================================
    // Sample clock path
    // ========================================================================
    // Edge detect only, no minimum rate so slow clocks still pass
    always_comb
    begin
        ext_edge = ext_clk_in && !ext_prev_q;
        tick_d   = act_ext_q ? div_tick : int_clk_tick;
        sclk_d   = sclk_q ^ tick_d;
    end

    // Clock path flops; source only changes while stopped, so no runt pulse
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_prev_q <= 1'b0;
            tick_q     <= 1'b0;
            sclk_q     <= 1'b0;
        end
        else
        begin
            ext_prev_q <= ext_clk_in;
            tick_q     <= tick_d;
            sclk_q     <= sclk_d;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    always_comb
    begin
        hreadyout       = 1'b1;
        hresp           = HRESP_OKAY;
        hrdata          = rdata_q;
        sample_tick     = tick_q;
        sample_clk      = sclk_q;
        pll_ref_select  = act_ref_q;
        ext_range_code  = act_rng_q;
        // Connector is an input for external clock or external reference
        connector_input = act_ext_q || (act_ref_q == REF_SRC_CONNECTOR);
        term_enable     = act_term_q && connector_input;
    end

endmodule : ext_sample_clock_select

// *** verilog/clock_select_pkg.sv ***
// Constants, register map and types for the sample clock source selector
package clock_select_pkg;

    // ========================================================================
    // Register indices (byte address is four times the index)
    localparam logic [15:0] IDX_DIVIDER     = 16'h4E48;  // External clock divider
    localparam logic [15:0] IDX_EXT_SELECT  = 16'h4E84;  // External clock select
    localparam logic [15:0] IDX_TERMINATION = 16'h4E98;  // Clock input termination
    localparam logic [15:0] IDX_RANGE       = 16'h4EA2;  // External clock range
    localparam logic [15:0] IDX_REFERENCE   = 16'h4EAC;  // PLL reference source
    localparam logic [15:0] IDX_STATUS      = 16'h4EB6;  // Block status, read only

    // ========================================================================
    // Bus constants
    localparam int          ADDR_W        = 18;          // Decoded address bits
    localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;       // Transfer type bit 1
    localparam logic        HRESP_OKAY    = 1'b0;        // Only response used

    // ========================================================================
    // Reset values
    localparam logic [31:0] DIVIDER_RESET     = 32'h0000_0001;  // Divide by one
    localparam logic [31:0] EXT_SELECT_RESET  = 32'h0000_0000;  // Internal clock
    localparam logic [31:0] TERMINATION_RESET = 32'h0000_0000;  // High impedance
    localparam logic [31:0] RANGE_RESET       = 32'h0000_0002;  // Single range
    localparam logic [31:0] REFERENCE_RESET   = 32'h0000_0000;  // Internal reference

    // ========================================================================
    // Range codes, one-hot
    localparam logic [31:0] RANGE_SINGLE  = 32'h0000_0002;  // Single
    localparam logic [31:0] RANGE_BURST_S = 32'h0000_0004;  // Burst S
    localparam logic [31:0] RANGE_BURST_M = 32'h0000_0008;  // Burst M
    localparam logic [31:0] RANGE_BURST_L = 32'h0000_0010;  // Burst L
    localparam logic [31:0] range_code_burst_xlarge = 32'h0000_0020;  // Burst XL
    localparam int          RANGE_LSB     = 1;              // Lowest one-hot bit
    localparam int          RANGE_W       = 5;              // Number of ranges

    // ========================================================================
    // Reference source codes
    localparam logic [31:0] REF_INTERNAL_CODE        = 32'h0000_0000;  // Internal
    localparam logic [31:0] backplane_reference_code = 32'hFFFF_FFFF;  // Backplane

    // ========================================================================
    // Divider
    localparam int DIV_W = 11;  // Holds the largest ratio

    // ========================================================================
    // Status field positions
    localparam int ST_RUN      = 0;  // Board running
    localparam int ST_EXT      = 1;  // External clock in use
    localparam int ST_TERM     = 2;  // Termination switched on
    localparam int ST_REF_LSB  = 3;  // Reference source, two bits
    localparam int ST_CONN_IN  = 5;  // Connector used as an input
    localparam int ST_REJECT   = 6;  // Last range or divider write refused

    // PLL reference routing
    typedef enum logic [1:0] {
        REF_SRC_INTERNAL,
        REF_SRC_BACKPLANE,
        REF_SRC_CONNECTOR
    } ref_src_t;

    // True for every permitted divider ratio
    function automatic logic valid_ratio(input logic [31:0] r);
        case (r)
            32'h1, 32'h2, 32'h4, 32'h8, 32'hA, 32'h10, 32'h14, 32'h28, 32'h32,
            32'h50, 32'h64, 32'hC8, 32'h190, 32'h1F4, 32'h320, 32'h3E8,
            32'h7D0: valid_ratio = 1'b1;
            default: valid_ratio = 1'b0;
        endcase
    endfunction : valid_ratio

    // True for the five one-hot range codes
    function automatic logic valid_range(input logic [31:0] r);
        case (r)
            RANGE_SINGLE, RANGE_BURST_S, RANGE_BURST_M, RANGE_BURST_L,
            range_code_burst_xlarge: valid_range = 1'b1;
            default:                 valid_range = 1'b0;
        endcase
    endfunction : valid_range

endpackage : clock_select_pkg

// *** verilog/ratio_divider.sv ***
// Edge counter that passes one tick out of every programmed ratio
`timescale 1ns/1ns
module ratio_divider
    import clock_select_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Control
    input  wire logic             clear,
    input  wire logic [DIV_W-1:0] ratio,
    // Ticks
    input  wire logic             tick_in,
    output logic                  tick_out
);

    logic [DIV_W-1:0] count_q;  // Ticks seen since last output
    logic [DIV_W-1:0] count_d;  // Next count

    // ========================================================================
    // Count next value
    // Wraps at ratio minus one and emits a pulse there
    always_comb
    begin
        count_d  = count_q;
        tick_out = 1'b0;
        if (clear)
        begin
            count_d = '0;
        end
        else if (tick_in)
        begin
            if (count_q >= ratio - DIV_W'(1))
            begin
                count_d  = '0;
                tick_out = 1'b1;
            end
            else
            begin
                count_d = count_q + DIV_W'(1);
            end
        end
    end

    // Count register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count_q <= '0;
        else
            count_q <= count_d;
    end

endmodule : ratio_divider

// *** tb/ext_sample_clock_select_properties.sv ***
// Concurrent checks on the clock path outputs of the sample clock selector
`timescale 1ns/1ns
module ext_sample_clock_select_checker
    import clock_select_pkg::*;
(
    // Clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // Watched ports
    input  wire logic               run,
    input  wire logic               ext_clk_in,
    input  wire logic               int_clk_tick,
    input  wire logic               sample_tick,
    input  wire logic               sample_clk,
    input  wire logic               term_enable,
    input  wire logic               connector_input,
    input  wire logic [1:0]         pll_ref_select,
    input  wire logic [RANGE_W-1:0] ext_range_code
);
    // ========================================================================
    // Properties, all in the bus clock domain
    default clocking dc @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Internal source settled: tick follows the internal enable one cycle on
    property p_internal; !connector_input && !$past(connector_input)
        && !$past(connector_input, 2) |-> sample_tick == $past(int_clk_tick); endproperty
    a_internal: assert property (p_internal) else $error("internal tick not passed");
    // Every tick has an internal pulse or a recent external rise behind it
    property p_tick_cause; sample_tick |-> $past(int_clk_tick)
        || ($past(ext_clk_in) && !$past(ext_clk_in, 2))
        || ($past(ext_clk_in, 2) && !$past(ext_clk_in, 3))
        || ($past(ext_clk_in, 3) && !$past(ext_clk_in, 4)); endproperty
    a_tick_cause: assert property (p_tick_cause) else $error("tick without cause");
    // Sample clock level turns over exactly with each tick
    property p_clk_toggle; sample_tick == (sample_clk != $past(sample_clk)); endproperty
    a_clk_toggle: assert property (p_clk_toggle) else $error("sample clock out of step");
    // Termination only on an input connector
    property p_term; term_enable |-> connector_input; endproperty
    a_term: assert property (p_term) else $error("termination on output connector");
    // Active range is always one of the five codes
    property p_range; $onehot(ext_range_code); endproperty
    a_range: assert property (p_range) else $error("range code not one-hot");
    // Reference routing legal, connector reference makes the connector an input
    property p_ref; pll_ref_select != 2'h3 && (pll_ref_select != 2'h2 || connector_input);
    endproperty
    a_ref: assert property (p_ref) else $error("bad reference routing");
    // No reference, range or connector setting moves while the board runs
    property p_freeze; $past(run) |-> $stable(pll_ref_select) && $stable(ext_range_code);
    endproperty
    a_freeze: assert property (p_freeze) else $error("setting changed while running");
    property p_freeze_conn; $past(run) |-> $stable(term_enable) && $stable(connector_input);
    endproperty
    a_freeze_conn: assert property (p_freeze_conn) else $error("connector changed running");
endmodule : ext_sample_clock_select_checker

bind ext_sample_clock_select ext_sample_clock_select_checker u_checker (
    .hclk(hclk), .hresetn(hresetn), .run(run), .ext_clk_in(ext_clk_in),
    .int_clk_tick(int_clk_tick), .sample_tick(sample_tick), .sample_clk(sample_clk),
    .term_enable(term_enable), .connector_input(connector_input),
    .pll_ref_select(pll_ref_select), .ext_range_code(ext_range_code));

// *** tb/ext_clock_source.sv ***
// Behavioural external clock source on the clock connector
`timescale 1ns/1ns
module ext_clock_source
(
    // Clock and control
    input  wire logic       hclk,
    input  wire logic       enable,
    input  wire logic [3:0] half_cycles,
    // Clock into the connector
    output logic            clk_out
);
    logic [3:0] count_q;  // Cycles spent in this half period

    // Fixed rate while enabled, stands low between frames
    always @(posedge hclk)
    begin
        if (!enable)
        begin
            count_q <= 4'h1;
            clk_out <= 1'b0;
        end
        else if (count_q == half_cycles)
        begin
            count_q <= 4'h1;
            clk_out <= ~clk_out;
        end
        else
            count_q <= count_q + 4'h1;
    end
endmodule : ext_clock_source

// *** tb/ext_sample_clock_select_tb_top.sv ***
// Self-checking bench for the sample clock source selector
`timescale 1ns/1ns
module ext_sample_clock_select_tb_top
    import clock_select_pkg::*;
();
    logic hclk, hresetn, hsel, hwrite, run, int_clk_tick, ext_en, ext_q;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, pll_ref_select;
    logic [2:0] hsize;
    logic [RANGE_W-1:0] ext_range_code;
    logic hreadyout, hresp, ext_clk_in, sample_tick, sample_clk, term_enable, connector_input;
    int bad_count, compares, ticks, rises;
    int ratios[3] = '{1, 2, 10};

    // ========================================================================
    // Clock, design and far side
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    ext_sample_clock_select DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .run(run),
        .ext_clk_in(ext_clk_in), .int_clk_tick(int_clk_tick), .sample_tick(sample_tick),
        .sample_clk(sample_clk), .term_enable(term_enable), .connector_input(connector_input),
        .pll_ref_select(pll_ref_select), .ext_range_code(ext_range_code));
    ext_clock_source SRC (.hclk(hclk), .enable(ext_en), .half_cycles(4'h3),
        .clk_out(ext_clk_in));

    // Count external rises and sample ticks
    always @(posedge hclk)
    begin
        ext_q <= ext_clk_in;
        if (sample_tick === 1'b1) ticks <= ticks + 1;
        if (ext_clk_in === 1'b1 && ext_q === 1'b0) rises <= rises + 1;
    end

    // ========================================================================
    // Shared tasks
    task automatic conclude();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : cyc
    // Bounded wait for hready at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 100)
            begin
                bad_count++;
                conclude();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy
    // One single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {14'h0000, idx, 2'b00};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        cmp(rd, exp);
    endtask : rchk

    // ========================================================================
    // Scenarios
    task automatic s_reset_values();
        rchk(IDX_DIVIDER, DIVIDER_RESET);
        rchk(IDX_EXT_SELECT, EXT_SELECT_RESET);
        rchk(IDX_TERMINATION, TERMINATION_RESET);
        rchk(IDX_RANGE, RANGE_RESET);
        rchk(IDX_REFERENCE, REFERENCE_RESET);
        rchk(IDX_STATUS, 32'h0);
        bus(1'b1, IDX_STATUS + 16'h0001, 32'hFFFF_FFFF);
        rchk(IDX_STATUS + 16'h0001, 32'h0);
        cmp({26'h0, hresp, ext_range_code}, 32'h1);
    endtask : s_reset_values
    // All five range codes, then a refused code
    task automatic s_range();
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, IDX_RANGE, 32'h2 << i);
            rchk(IDX_RANGE, 32'h2 << i);
            cyc(2);
            cmp({27'h0, ext_range_code}, 32'h1 << i);
        end
        bus(1'b1, IDX_RANGE, 32'h6);
        rchk(IDX_RANGE, range_code_burst_xlarge);
        rchk(IDX_STATUS, 32'h40);
        bus(1'b1, IDX_RANGE, RANGE_SINGLE);
    endtask : s_range
    // Internal enable passes one cycle later, one cycle wide
    task automatic s_internal();
        @(posedge hclk);
        int_clk_tick <= 1'b1;
        @(posedge hclk);
        int_clk_tick <= 1'b0;
        #1;
        cmp({30'h0, sample_clk, sample_tick}, 32'h3);
        cyc(1);
        cmp({30'h0, sample_clk, sample_tick}, 32'h2);
    endtask : s_internal
    // External clock through the divider at several ratios
    task automatic s_divider();
        int t0, r0;
        bus(1'b1, IDX_DIVIDER, 32'h3);
        rchk(IDX_DIVIDER, DIVIDER_RESET);
        foreach (ratios[k])
        begin
            bus(1'b1, IDX_EXT_SELECT, 32'h0);
            bus(1'b1, IDX_DIVIDER, ratios[k]);
            bus(1'b1, IDX_EXT_SELECT, 32'h1);
            cyc(2);
            t0 = ticks;
            r0 = rises;
            @(posedge hclk);
            ext_en <= 1'b1;
            repeat (120) @(posedge hclk);
            ext_en <= 1'b0;
            cyc(6);
            cmp(ticks - t0, (rises - r0) / ratios[k]);
        end
        rchk(IDX_STATUS, 32'h22);
        bus(1'b1, IDX_EXT_SELECT, 32'h0);
    endtask : s_divider
    // Backplane and connector references, termination gating
    task automatic s_reference();
        bus(1'b1, IDX_TERMINATION, 32'h1);
        bus(1'b1, IDX_REFERENCE, backplane_reference_code);
        cyc(2);
        cmp({30'h0, pll_ref_select}, 32'h1);
        cmp({30'h0, connector_input, term_enable}, 32'h0);
        bus(1'b1, IDX_REFERENCE, 32'h0098_9680);
        cyc(2);
        cmp({30'h0, pll_ref_select}, 32'h2);
        cmp({30'h0, connector_input, term_enable}, 32'h3);
        rchk(IDX_STATUS, 32'h34);
        bus(1'b1, IDX_REFERENCE, REF_INTERNAL_CODE);
        cyc(2);
        cmp({28'h0, pll_ref_select, connector_input, term_enable}, 32'h0);
    endtask : s_reference
    // Writes while running wait until the board stops
    task automatic s_freeze();
        @(posedge hclk);
        run <= 1'b1;
        bus(1'b1, IDX_RANGE, RANGE_BURST_M);
        bus(1'b1, IDX_REFERENCE, backplane_reference_code);
        cyc(4);
        cmp({27'h0, ext_range_code}, 32'h1);
        cmp({30'h0, pll_ref_select}, 32'h0);
        rchk(IDX_RANGE, RANGE_BURST_M);
        @(posedge hclk);
        run <= 1'b0;
        cyc(3);
        cmp({27'h0, ext_range_code}, 32'h4);
        cmp({30'h0, pll_ref_select}, 32'h1);
    endtask : s_freeze

    // ========================================================================
    // Main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        run = 1'b0;
        int_clk_tick = 1'b0;
        ext_en = 1'b0;
        bad_count = 0;
        compares = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        s_reset_values();
        s_range();
        s_internal();
        s_divider();
        s_reference();
        s_freeze();
        conclude();
    end
endmodule : ext_sample_clock_select_tb_top
